// ==== core/mcs_config_bank.sv ====
// manufacturer configuration and security command bank
//
// Notes on behaviour
// R01: the minimum duty word holds min duty in ns in its upper byte and min dead time in ns below.
// R02: the clamp word holds a 7-bit pulse delay in units of 4 ns in bits 14:8.
// R03: the clamp word holds an 8-bit pulse width in units of 4 ns in its low byte.
// R04: clamp mode 0 runs 1x frequency with B inverted to A, mode 1 runs 2x on A only.
// R05: the clamp command is read only and a write to it is refused.
// R06: with the second strap used for sync, the address is the first strap address plus n.
// R07: the bus voltage block holds mid-to-high and high-to-mid current thresholds on top.
// R08: below them sit mid voltage, low-to-mid, mid-to-low thresholds and low voltage.
// R09: the debug buffer is an 8-byte block that can be written and read back.
// R10: a password setup write carries the current then the new 6-byte ASCII password.
// R11: security turns on once a valid new password is accepted.
// R12: a setup read gives zero while security is off and a distinct value when locked out.
// R13: the current password written to the suspend command lifts protection until reset.
// R14: the suspend command is refused while security is off.
// R15: while security holds, commands whose mask bit is set are write protected; here the setup and suspend commands never are.
// R16: a setup write with the wrong current password changes nothing; here each one still counts toward the lock-out.
`timescale 1ns/1ps
module mcs_config_bank
  import mcs_pkg::*;
#(
  parameter logic [1:0] PW_TRIES = MCS_PW_TRIES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] cmdCode,
  input wire logic wrStrobe,
  input wire logic [3:0] wrCount,
  input wire logic [95:0] wrData,
  input wire logic rdStrobe,
  input wire logic [15:0] clampCfg,
  input wire logic [255:0] protectMask,
  input wire logic debugCapture,
  input wire logic [63:0] debugIn,
  input wire logic [6:0] strapFirstAddrPin,
  input wire logic strapSecondSyncPin,
  output logic cmdAck,
  output logic cmdNack,
  output logic rdValid,
  output logic [95:0] rdData,
  output logic [3:0] rdCount,
  output logic cmdProtected,
  output logic [7:0] minDutyNs,
  output logic [7:0] minDeadNs,
  output logic [6:0] clampDelay,
  output logic [7:0] clampWidth,
  output logic clampDoubleFreq,
  output logic clampBEnable,
  output logic clampBInvert,
  output logic [6:0] busAddress,
  output logic [7:0] dbvMidToHigh,
  output logic [7:0] dbvHighToMid,
  output logic [7:0] dbvVoltMid,
  output logic [7:0] dbvLowToMid,
  output logic [7:0] dbvMidToLow,
  output logic [7:0] dbvVoltLow,
  output logic [63:0] debugBuffer,
  output logic securityOn,
  output logic securitySuspended,
  output logic passwordLocked
);
  // transfer length of each command in this bank, zero when the code is not ours
  function automatic logic [3:0] cmdLength(input logic [7:0] code);
    unique case (code)
      MCS_CMD_MIN_DUTY: cmdLength = MCS_LEN_WORD;
      MCS_CMD_CLAMP: cmdLength = MCS_LEN_WORD;
      MCS_CMD_ADDR_OFS: cmdLength = MCS_LEN_BYTE;
      MCS_CMD_DBV: cmdLength = MCS_LEN_DBV;
      MCS_CMD_DEBUG: cmdLength = MCS_LEN_DEBUG;
      MCS_CMD_PW_SETUP: cmdLength = MCS_LEN_PW_SETUP;
      MCS_CMD_SUSPEND: cmdLength = MCS_LEN_SUSPEND;
      default: cmdLength = MCS_LEN_NONE;
    endcase
  endfunction

  // register state
  logic [15:0] minDuty_r;
  logic [15:0] minDuty_nxt;
  logic [7:0] addrOfs_r;
  logic [7:0] addrOfs_nxt;
  logic [47:0] dbv_r;
  logic [47:0] dbv_nxt;
  logic [63:0] debug_r;
  logic [63:0] debug_nxt;
  logic ack_r;
  logic ack_nxt;
  logic nack_r;
  logic nack_nxt;
  logic rdValid_r;
  logic [95:0] rdData_r;
  logic [95:0] rdData_nxt;
  logic [3:0] rdCount_r;
  logic [3:0] rdCount_nxt;
  logic [6:0] busAddr_r;

  // strap pins are asynchronous, two stages before use
  logic [6:0] strapAddrMeta_r;
  logic [6:0] strapAddrSync_r;
  logic strapSyncMeta_r;
  logic strapSyncSync_r;

  // security core
  logic secOn;
  logic secSusp;
  logic pwLock;
  logic setupOk;
  logic suspendOk;

  // decode
  wire logic [3:0] expLen = cmdLength(cmdCode);
  wire logic isOurs = expLen != MCS_LEN_NONE;
  wire logic lenOk = wrCount == expLen;
  wire logic isSetup = cmdCode == MCS_CMD_PW_SETUP;
  wire logic isSuspend = cmdCode == MCS_CMD_SUSPEND;
  wire logic isClamp = cmdCode == MCS_CMD_CLAMP;
  // the password commands stay reachable so that security can still be lifted
  wire logic maskHit = protectMask[cmdCode] && !isSetup && !isSuspend;
  assign cmdProtected = secOn && !secSusp && maskHit; // R15
  wire logic wrTake = wrStrobe && isOurs && lenOk && !cmdProtected && !isClamp; // R05 R15
  wire logic setupWr = wrTake && isSetup;
  wire logic suspendWr = wrTake && isSuspend;
  wire logic secRefuse = (isSetup && !setupOk) || (isSuspend && !suspendOk); // R14 R16
  wire logic wrStore = wrTake && !isSetup && !isSuspend;

  mcs_security #(
    .TRIES(PW_TRIES)
  ) u_security (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .setupWr(setupWr), // R10
    .suspendWr(suspendWr),
    .wrData(wrData),
    .secOn(secOn),
    .secSuspended(secSusp),
    .pwLocked(pwLock),
    .setupOk(setupOk),
    .suspendOk(suspendOk)
  );

  // register writes
  assign minDuty_nxt = (wrStore && cmdCode == MCS_CMD_MIN_DUTY) ? wrData[15:0] : minDuty_r; // R01
  assign addrOfs_nxt = (wrStore && cmdCode == MCS_CMD_ADDR_OFS) ? wrData[7:0] : addrOfs_r;
  assign dbv_nxt = (wrStore && cmdCode == MCS_CMD_DBV) ? wrData[47:0] : dbv_r; // R07 R08
  wire logic debugWr = wrStore && cmdCode == MCS_CMD_DEBUG;
  // a host write wins over a capture in the same cycle so the host sees what it wrote
  assign debug_nxt = debugWr ? wrData[63:0] : (debugCapture ? debugIn : debug_r); // R09

  // answer to a write: one pulse in the cycle after the strobe
  assign ack_nxt = wrTake && !secRefuse;
  assign nack_nxt = wrStrobe && isOurs && !(wrTake && !secRefuse); // R05 R14 R16

  // password setup read value
  wire logic [95:0] pwRead = pwLock ? MCS_PW_READ_LOCKED :
    (secOn ? MCS_PW_READ_ON : MCS_PW_READ_OFF); // R12

  // read mux, suspend command reads as zero so the password never leaves the block
  always_comb
  begin
    rdData_nxt = 96'h0;
    unique case (cmdCode)
      MCS_CMD_MIN_DUTY: rdData_nxt[15:0] = minDuty_r;
      MCS_CMD_CLAMP: rdData_nxt[15:0] = clampCfg; // R05
      MCS_CMD_ADDR_OFS: rdData_nxt[7:0] = addrOfs_r;
      MCS_CMD_DBV: rdData_nxt[47:0] = dbv_r;
      MCS_CMD_DEBUG: rdData_nxt[63:0] = debug_r; // R09
      MCS_CMD_PW_SETUP: rdData_nxt = pwRead;
      default: rdData_nxt = 96'h0;
    endcase
  end
  assign rdCount_nxt = expLen;

  // address: strap address, plus offset when the second strap serves as sync
  wire logic [7:0] addrSum = {1'b0, strapAddrSync_r} + addrOfs_r;
  wire logic [6:0] busAddr_nxt = strapSyncSync_r ? addrSum[6:0] : strapAddrSync_r; // R06

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strapAddrMeta_r <= 7'h00;
      strapAddrSync_r <= 7'h00;
      strapSyncMeta_r <= 1'b0;
      strapSyncSync_r <= 1'b0;
    end
    else if (ce)
    begin
      strapAddrMeta_r <= strapFirstAddrPin;
      strapAddrSync_r <= strapAddrMeta_r;
      strapSyncMeta_r <= strapSecondSyncPin;
      strapSyncSync_r <= strapSyncMeta_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      minDuty_r <= MCS_MIN_DUTY_RST;
      addrOfs_r <= MCS_ADDR_OFS_RST;
      dbv_r <= MCS_DBV_RST;
      debug_r <= MCS_DEBUG_RST;
      busAddr_r <= 7'h00;
    end
    else if (ce)
    begin
      minDuty_r <= minDuty_nxt;
      addrOfs_r <= addrOfs_nxt;
      dbv_r <= dbv_nxt;
      debug_r <= debug_nxt;
      busAddr_r <= busAddr_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      nack_r <= 1'b0;
      rdValid_r <= 1'b0;
      rdData_r <= 96'h0;
      rdCount_r <= MCS_LEN_NONE;
    end
    else if (ce)
    begin
      ack_r <= ack_nxt;
      nack_r <= nack_nxt;
      rdValid_r <= rdStrobe && isOurs && !isSuspend;
      if (rdStrobe && isOurs)
      begin
        rdData_r <= rdData_nxt;
        rdCount_r <= rdCount_nxt;
      end
    end
  end

  // field outputs
  assign minDutyNs = minDuty_r[MCS_DUTY_POS +: 8]; // R01
  assign minDeadNs = minDuty_r[MCS_DEAD_POS +: 8]; // R01
  assign clampDelay = clampCfg[MCS_CLAMP_DELAY_POS +: MCS_CLAMP_DELAY_W]; // R02
  assign clampWidth = clampCfg[MCS_CLAMP_WIDTH_POS +: 8]; // R03
  // mode 0: both outputs at 1x, B in antiphase; mode 1: A alone at twice the rate
  wire logic clampMode1x = clampCfg[MCS_CLAMP_MODE_POS] == MCS_CLAMP_MODE_1X_INV;
  assign clampDoubleFreq = !clampMode1x; // R04
  assign clampBEnable = clampMode1x; // R04
  assign clampBInvert = clampMode1x; // R04
  assign busAddress = busAddr_r;
  assign dbvMidToHigh = dbv_r[MCS_DBV_MID_HIGH_POS +: 8]; // R07
  assign dbvHighToMid = dbv_r[MCS_DBV_HIGH_MID_POS +: 8]; // R07
  assign dbvVoltMid = dbv_r[MCS_DBV_VMID_POS +: 8]; // R08
  assign dbvLowToMid = dbv_r[MCS_DBV_LOW_MID_POS +: 8]; // R08
  assign dbvMidToLow = dbv_r[MCS_DBV_MID_LOW_POS +: 8]; // R08
  assign dbvVoltLow = dbv_r[MCS_DBV_VLOW_POS +: 8]; // R08
  assign debugBuffer = debug_r;
  assign securityOn = secOn;
  assign securitySuspended = secSusp;
  assign passwordLocked = pwLock;
  assign cmdAck = ack_r;
  assign cmdNack = nack_r;
  assign rdValid = rdValid_r;
  assign rdData = rdData_r;
  assign rdCount = rdCount_r;
endmodule

// ==== pkg/mcs_pkg.sv ====
// package: command codes, lengths, field positions and reset values of the config/security bank
package mcs_pkg;
  // command codes
  localparam logic [7:0] MCS_CMD_MIN_DUTY = 8'hEB;
  localparam logic [7:0] MCS_CMD_CLAMP = 8'hEC;
  localparam logic [7:0] MCS_CMD_ADDR_OFS = 8'hEE;
  localparam logic [7:0] MCS_CMD_DBV = 8'hEF;
  localparam logic [7:0] MCS_CMD_DEBUG = 8'hF0;
  localparam logic [7:0] MCS_CMD_PW_SETUP = 8'hF1;
  localparam logic [7:0] MCS_CMD_SUSPEND = 8'hF2;
  // transfer lengths in bytes
  localparam logic [3:0] MCS_LEN_NONE = 4'h0;
  localparam logic [3:0] MCS_LEN_BYTE = 4'h1;
  localparam logic [3:0] MCS_LEN_WORD = 4'h2;
  localparam logic [3:0] MCS_LEN_DBV = 4'h6;
  localparam logic [3:0] MCS_LEN_DEBUG = 4'h8;
  localparam logic [3:0] MCS_LEN_PW_SETUP = 4'hC;
  localparam logic [3:0] MCS_LEN_SUSPEND = 4'h6;
  // minimum duty word
  localparam int MCS_DUTY_POS = 8;
  localparam int MCS_DEAD_POS = 0;
  // clamp word
  localparam int MCS_CLAMP_MODE_POS = 15;
  localparam int MCS_CLAMP_DELAY_POS = 8;
  localparam int MCS_CLAMP_DELAY_W = 7;
  localparam int MCS_CLAMP_WIDTH_POS = 0;
  localparam logic MCS_CLAMP_MODE_1X_INV = 1'b0;
  // dynamic bus voltage block
  localparam int MCS_DBV_MID_HIGH_POS = 40;
  localparam int MCS_DBV_HIGH_MID_POS = 32;
  localparam int MCS_DBV_VMID_POS = 24;
  localparam int MCS_DBV_LOW_MID_POS = 16;
  localparam int MCS_DBV_MID_LOW_POS = 8;
  localparam int MCS_DBV_VLOW_POS = 0;
  // password block
  localparam int MCS_PW_CUR_POS = 48;
  localparam int MCS_PW_W = 48;
  // reset values
  localparam logic [15:0] MCS_MIN_DUTY_RST = 16'h0000;
  localparam logic [7:0] MCS_ADDR_OFS_RST = 8'h00;
  localparam logic [47:0] MCS_DBV_RST = 48'h0000_0000_0000;
  localparam logic [63:0] MCS_DEBUG_RST = 64'h0000_0000_0000_0000;
  localparam logic [47:0] MCS_PW_RST = 48'h3030_3030_3030;
  // password setup read answers
  localparam logic [95:0] MCS_PW_READ_OFF = 96'h0;
  localparam logic [95:0] MCS_PW_READ_ON = 96'h1;
  localparam logic [95:0] MCS_PW_READ_LOCKED = 96'h2;
  localparam logic [1:0] MCS_PW_TRIES = 2'h3;
endpackage

// ==== core/mcs_security.sv ====
// password store, security state, lock-out and one-time suspend
`timescale 1ns/1ps
module mcs_security
  import mcs_pkg::*;
#(
  parameter logic [1:0] TRIES = MCS_PW_TRIES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic setupWr,
  input wire logic suspendWr,
  input wire logic [95:0] wrData,
  output logic secOn,
  output logic secSuspended,
  output logic pwLocked,
  output logic setupOk,
  output logic suspendOk
);
  logic [47:0] pw_r;
  logic [47:0] pw_nxt;
  logic secOn_r;
  logic secOn_nxt;
  logic susp_r;
  logic susp_nxt;
  logic [1:0] fails_r;
  logic [1:0] fails_nxt;
  logic lock_r;
  logic lock_nxt;

  wire logic [47:0] curGiven = wrData[MCS_PW_CUR_POS +: MCS_PW_W];
  wire logic [47:0] newGiven = wrData[MCS_PW_W-1:0];
  wire logic setupMatch = curGiven == pw_r;
  wire logic suspendMatch = newGiven == pw_r;
  // a locked setup refuses everything until reset, so guessing cannot continue
  assign setupOk = !lock_r && setupMatch;
  assign suspendOk = secOn_r && suspendMatch; // R14
  wire logic setupBad = setupWr && !lock_r && !setupMatch;
  wire logic [1:0] failsInc = fails_r + 2'h1;

  assign pw_nxt = (setupWr && setupOk) ? newGiven : pw_r; // R16
  assign secOn_nxt = secOn_r || (setupWr && setupOk); // R11
  assign susp_nxt = susp_r || (suspendWr && suspendOk); // R13
  assign fails_nxt = setupBad ? failsInc : fails_r;
  assign lock_nxt = lock_r || (setupBad && failsInc >= TRIES); // R12

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pw_r <= MCS_PW_RST;
      secOn_r <= 1'b0;
      susp_r <= 1'b0;
      fails_r <= 2'h0;
      lock_r <= 1'b0;
    end
    else if (ce)
    begin
      pw_r <= pw_nxt;
      secOn_r <= secOn_nxt;
      susp_r <= susp_nxt;
      fails_r <= fails_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign secOn = secOn_r;
  assign secSuspended = susp_r;
  assign pwLocked = lock_r;
endmodule

// ==== tb/mcs_host.sv ====
// host-side model issuing bank writes and reads
`timescale 1ns/1ps
module mcs_host
  import mcs_pkg::*;
(
  input wire logic clk,
  input wire logic cmdAck,
  input wire logic cmdNack,
  input wire logic rdValid,
  output logic [7:0] cmdCode,
  output logic wrStrobe,
  output logic [3:0] wrCount,
  output logic [95:0] wrData,
  output logic rdStrobe
);
  initial
  begin
    cmdCode = 8'h00;
    wrStrobe = 1'b0;
    wrCount = 4'h0;
    wrData = 96'h0;
    rdStrobe = 1'b0;
  end
  // setup data is current then new password, twelve bytes
  task automatic wr(input logic [7:0] c, input logic [3:0] n, input logic [95:0] d,
    output logic [1:0] an);
    @(negedge clk);
    cmdCode = c;
    wrCount = n;
    wrData = d;
    wrStrobe = 1'b1;
    @(negedge clk);
    wrStrobe = 1'b0;
    // stale data is inverted so nothing can lean on it
    wrData = ~d;
    an = {cmdAck, cmdNack};
  endtask
  task automatic rd(input logic [7:0] c, output logic v);
    @(negedge clk);
    cmdCode = c;
    rdStrobe = 1'b1;
    @(negedge clk);
    rdStrobe = 1'b0;
    v = rdValid;
  endtask
endmodule

// ==== tb/mcs_config_bank_assertions.sv ====
// concurrent checks on the config and security bank ports
`timescale 1ns/1ps
module mcs_config_bank_assertions
  import mcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] cmdCode,
  input wire logic wrStrobe,
  input wire logic [15:0] clampCfg,
  input wire logic [255:0] protectMask,
  input wire logic cmdAck,
  input wire logic cmdNack,
  input wire logic cmdProtected,
  input wire logic [6:0] clampDelay,
  input wire logic [7:0] clampWidth,
  input wire logic clampDoubleFreq,
  input wire logic clampBEnable,
  input wire logic clampBInvert,
  input wire logic securityOn,
  input wire logic securitySuspended,
  input wire logic passwordLocked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic wrTake = ce && wrStrobe;
  clamp_fields_a: assert property (clampDelay == clampCfg[14:8] && clampWidth == clampCfg[7:0])
    else $error("clamp timing fields differ from clamp word");
  clamp_mode_a: assert property (clampDoubleFreq == clampCfg[15] && clampBEnable != clampCfg[15]
    && clampBInvert != clampCfg[15]) else $error("clamp mode outputs wrong");
  clamp_nack_a: assert property (wrTake && cmdCode == MCS_CMD_CLAMP |=> cmdNack && !cmdAck)
    else $error("clamp write not refused");
  suspend_off_a: assert property (wrTake && cmdCode == MCS_CMD_SUSPEND && !securityOn |=> cmdNack)
    else $error("suspend accepted with security off");
  mask_protect_a: assert property (cmdProtected == (securityOn && !securitySuspended
    && protectMask[cmdCode] && cmdCode != MCS_CMD_PW_SETUP && cmdCode != MCS_CMD_SUSPEND))
    else $error("protect flag disagrees with mask");
  sec_rise_a: assert property ($rose(securityOn) |-> cmdAck && $past(cmdCode) == MCS_CMD_PW_SETUP)
    else $error("security on without accepted setup");
  sec_hold_a: assert property (securityOn |=> securityOn)
    else $error("security dropped before reset");
  suspend_rise_a: assert property ($rose(securitySuspended) |-> securityOn && cmdAck)
    else $error("suspend without accepted write");
  lock_rise_a: assert property ($rose(passwordLocked) |-> cmdNack && $past(cmdCode) == 8'hF1)
    else $error("lock without refused setup");
endmodule
bind mcs_config_bank mcs_config_bank_assertions u_chk (.clk, .rst, .ce, .cmdCode, .wrStrobe,
  .clampCfg, .protectMask, .cmdAck, .cmdNack, .cmdProtected, .clampDelay, .clampWidth,
  .clampDoubleFreq, .clampBEnable, .clampBInvert, .securityOn, .securitySuspended,
  .passwordLocked);

// ==== tb/tb_mcs_config_bank.sv ====
// self-checking bench for the config and security bank
`timescale 1ns/1ps
module tb_mcs_config_bank
  import mcs_pkg::*;
;
  typedef struct packed {logic [7:0] c; logic [3:0] n; logic [95:0] d; logic [1:0] an;
    logic [3:0] rc; logic [95:0] rd;} mcs_row_t;
  localparam logic [47:0] PW0 = 48'h303030303030;
  localparam logic [47:0] PW1 = 48'h414243444546;
  mcs_row_t rows [6] = '{
    '{MCS_CMD_MIN_DUTY, 4'h2, 96'h1234, 2'h2, 4'h2, 96'h1234},
    '{MCS_CMD_MIN_DUTY, 4'h1, 96'h55, 2'h1, 4'h2, 96'h1234},
    '{MCS_CMD_ADDR_OFS, 4'h1, 96'h05, 2'h2, 4'h1, 96'h05},
    '{MCS_CMD_DBV, 4'h6, 96'h112233445566, 2'h2, 4'h6, 96'h112233445566},
    '{MCS_CMD_DEBUG, 4'h8, 96'h0102030405060708, 2'h2, 4'h8, 96'h0102030405060708},
    '{MCS_CMD_CLAMP, 4'h2, 96'hFFFF, 2'h1, 4'h2, 96'hA5C3}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] clampCfg = 16'hA5C3;
  logic [255:0] protectMask = '0;
  logic ce = 1'b1;
  logic debugCapture = 1'b0;
  logic [63:0] debugIn = 64'h0;
  logic strapSync = 1'b1;
  wire logic [63:0] debugBuffer;
  logic [1:0] an;
  logic v;
  int badCount = 0;
  int totalChecks = 0;
  int cyc = 0;
  wire logic [7:0] cmdCode;
  wire logic [3:0] wrCount, rdCount;
  wire logic [95:0] wrData, rdData;
  wire logic wrStrobe, rdStrobe, cmdAck, cmdNack, rdValid, cmdProtected;
  wire logic [7:0] minDutyNs, minDeadNs, clampWidth;
  wire logic [6:0] clampDelay, busAddress;
  wire logic [2:0] clampMode;
  wire logic [47:0] dbvAll;
  wire logic securityOn, securitySuspended, passwordLocked;
  mcs_host u_mcs_host (.clk(clk), .cmdAck(cmdAck), .cmdNack(cmdNack), .rdValid(rdValid),
    .cmdCode(cmdCode), .wrStrobe(wrStrobe), .wrCount(wrCount), .wrData(wrData),
    .rdStrobe(rdStrobe));
  mcs_config_bank u_mcs_config_bank (.clk(clk), .rst(rst), .ce(ce), .cmdCode(cmdCode),
    .wrStrobe(wrStrobe), .wrCount(wrCount), .wrData(wrData), .rdStrobe(rdStrobe),
    .clampCfg(clampCfg), .protectMask(protectMask), .debugCapture(debugCapture),
    .debugIn(debugIn), .strapFirstAddrPin(7'h10), .strapSecondSyncPin(strapSync),
    .cmdAck(cmdAck), .cmdNack(cmdNack),
    .rdValid(rdValid), .rdData(rdData), .rdCount(rdCount), .cmdProtected(cmdProtected),
    .minDutyNs(minDutyNs), .minDeadNs(minDeadNs), .clampDelay(clampDelay),
    .clampWidth(clampWidth), .clampDoubleFreq(clampMode[2]), .clampBEnable(clampMode[1]),
    .clampBInvert(clampMode[0]), .busAddress(busAddress), .dbvMidToHigh(dbvAll[47:40]),
    .dbvHighToMid(dbvAll[39:32]), .dbvVoltMid(dbvAll[31:24]), .dbvLowToMid(dbvAll[23:16]),
    .dbvMidToLow(dbvAll[15:8]), .dbvVoltLow(dbvAll[7:0]), .debugBuffer(debugBuffer),
    .securityOn(securityOn), .securitySuspended(securitySuspended),
    .passwordLocked(passwordLocked));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic resetDut();
    @(negedge clk);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // run needs under a hundred cycles
    if (cyc == 3000)
    begin
      badCount++;
      testDone();
    end
  end
  initial
  begin
    resetDut();
    chk({minDutyNs, minDeadNs, securityOn, passwordLocked}, 18'h0);
    foreach (rows[i])
    begin
      u_mcs_host.wr(rows[i].c, rows[i].n, rows[i].d, an);
      chk(an, rows[i].an);
      u_mcs_host.rd(rows[i].c, v);
      chk({v, rdCount, rdData}, {1'b1, rows[i].rc, rows[i].rd});
    end
    chk({minDutyNs, minDeadNs}, 16'h1234);
    chk(dbvAll, 48'h112233445566);
    chk({clampDelay, clampWidth, clampMode}, {7'h25, 8'hC3, 3'b100});
    clampCfg = 16'h25C3;
    #1 chk(clampMode, 3'b011);
    chk(busAddress, 7'h15);
    // capture path into the debug buffer, then read it back over the bank
    debugIn = 64'h1122334455667788;
    debugCapture = 1'b1;
    @(negedge clk);
    debugCapture = 1'b0;
    chk(debugBuffer, 64'h1122334455667788);
    u_mcs_host.rd(MCS_CMD_DEBUG, v);
    chk({v, rdData}, {1'b1, 96'h1122334455667788});
    // second strap back to address use: offset no longer applies after the sync stages
    strapSync = 1'b0;
    repeat (4) @(negedge clk);
    chk(busAddress, 7'h10);
    $display("rows done");
    u_mcs_host.wr(MCS_CMD_SUSPEND, 4'h6, {48'h0, PW0}, an);
    chk(an, 2'h1);
    u_mcs_host.rd(MCS_CMD_SUSPEND, v);
    chk({v, rdData}, {1'b0, 96'h0});
    u_mcs_host.rd(MCS_CMD_PW_SETUP, v);
    chk({v, rdCount, rdData}, {1'b1, 4'hC, 96'h0});
    protectMask[MCS_CMD_MIN_DUTY] = 1'b1;
    u_mcs_host.wr(MCS_CMD_PW_SETUP, 4'hC, {48'h313131313131, PW1}, an);
    chk({an, securityOn}, 3'b010);
    u_mcs_host.wr(MCS_CMD_PW_SETUP, 4'hC, {PW0, PW1}, an);
    chk({an, securityOn}, 3'b101);
    u_mcs_host.rd(MCS_CMD_PW_SETUP, v);
    chk({v, rdData}, {1'b1, MCS_PW_READ_ON});
    u_mcs_host.wr(MCS_CMD_MIN_DUTY, 4'h2, 96'h9999, an);
    chk({an, cmdProtected, minDutyNs}, {3'b011, 8'h12});
    u_mcs_host.wr(MCS_CMD_SUSPEND, 4'h6, {48'h0, PW1}, an);
    chk({an, securitySuspended}, 3'b101);
    u_mcs_host.wr(MCS_CMD_MIN_DUTY, 4'h2, 96'h5678, an);
    chk({an, minDutyNs, minDeadNs}, {2'h2, 16'h5678});
    // let the ack pulse clear first, a frozen block must then ignore a write
    @(negedge clk);
    ce = 1'b0;
    u_mcs_host.wr(MCS_CMD_MIN_DUTY, 4'h2, 96'h9ABC, an);
    chk({an, minDutyNs, minDeadNs}, {2'h0, 16'h5678});
    ce = 1'b1;
    $display("security done");
    resetDut();
    chk({securityOn, securitySuspended}, 2'h0);
    repeat (3) u_mcs_host.wr(MCS_CMD_PW_SETUP, 4'hC, {PW1, PW1}, an);
    u_mcs_host.rd(MCS_CMD_PW_SETUP, v);
    chk({passwordLocked, v, rdData}, {2'b11, MCS_PW_READ_LOCKED});
    u_mcs_host.wr(MCS_CMD_PW_SETUP, 4'hC, {PW0, PW1}, an);
    chk({an, securityOn}, 3'b010);
    $display("lock done");
    testDone();
  end
endmodule
